// *** hdl/sram_burst_pkg.sv ***
package sram_burst_pkg;
  localparam int LANE_BITS_DEF  = 9;
  localparam int LANES_DEF      = 4;
  localparam int ADDR_BITS_DEF  = 20;
  localparam int BURST_BITS     = 2;
  localparam logic [1:0] BURST_STEP  = 2'h1;
  localparam logic [1:0] BURST_ZERO  = 2'h0;
  localparam logic [1:0] BEAT_LAST   = 2'h3;

  typedef enum logic [1:0] {
    OP_IDLE  = 2'b00,
    OP_READ  = 2'b01,
    OP_WRITE = 2'b10
  } op_t;
endpackage

// *** hdl/sram_bus_if.sv ***
`timescale 1ns/1ns
interface sram_bus_if #(
  parameter int LANES     = 4,
  parameter int LANE_BITS = 9,
  parameter int ADDR_BITS = 20
);
  logic [ADDR_BITS-1:0]       addr;
  logic                       chipSelectLowFirst_n;
  logic                       chipSelectHigh;
  logic                       chipSelectLowSecond_n;
  logic                       processorAddrStrobe_n;
  logic                       controllerAddrStrobe_n;
  logic                       burstStep_n;
  logic                       globalWrite_n;
  logic                       byteWriteQualifier_n;
  logic [LANES-1:0]           laneWrite_n;
  logic                       outputEnable_n;
  logic                       sleepRequest;
  logic                       flowThroughSelect_n;
  logic                       linearOrderSelect_n;
  logic                       tieLowPin;
  logic [LANES*LANE_BITS-1:0] hostData;
  logic [LANES*LANE_BITS-1:0] hostDataOe;
  logic [LANES*LANE_BITS-1:0] sramData;
  logic [LANES*LANE_BITS-1:0] sramDataOe;
  logic [LANES*LANE_BITS-1:0] dataLine;

  // Resolved bus level; undriven bits read as zero
  assign dataLine = (hostData & hostDataOe) | (sramData & sramDataOe);

  modport device (
    input  addr, chipSelectLowFirst_n, chipSelectHigh,
    input  chipSelectLowSecond_n, processorAddrStrobe_n,
    input  controllerAddrStrobe_n, burstStep_n, globalWrite_n,
    input  byteWriteQualifier_n, laneWrite_n, outputEnable_n,
    input  sleepRequest, flowThroughSelect_n, linearOrderSelect_n,
    input  tieLowPin, dataLine,
    output sramData, sramDataOe
  );
  modport host (
    output addr, chipSelectLowFirst_n, chipSelectHigh,
    output chipSelectLowSecond_n, processorAddrStrobe_n,
    output controllerAddrStrobe_n, burstStep_n, globalWrite_n,
    output byteWriteQualifier_n, laneWrite_n, outputEnable_n,
    output sleepRequest, flowThroughSelect_n, linearOrderSelect_n,
    output tieLowPin, hostData, hostDataOe,
    input  dataLine
  );
endinterface

// *** hdl/sram_burst_device.sv ***
`timescale 1ns/1ns
// Summary of operation
// - Sample all synchronous inputs on rising clock.
// - Low address bits preset burst counter.
// - Counter steps only while advance asserted.
// - Linear counts up; interleaved XORs start.
// - Burst wraps to start on fifth clock.
// - Flow-through low, pipelined high or open.
// - Sleep high is standby, low active.
// - Open flow-through and sleep pins take safe defaults; open order pin reads X.
// - Selected only when enables all true.
// - Global write low writes all lanes.
// - Byte qualifier writes only enabled lanes.
// - Host may enable any lane combination.
// - Both writes high means read, all lanes.
// - Data outputs stay off during writes.
// - Lanes c and d only in wide configs.
// - Lane enable governs its lane; shared pins.
// - Controller strobe loads new address; processor strobe only while first low enable is low.
// - Output enable gates read drivers only.
// - Flow-through same cycle, pipeline one later.
// - Deselect turns outputs off one edge later (flow), two (pipeline).
// - Dummy read still advances burst counter.
module sram_burst_device
  import sram_burst_pkg::*;
#(
  parameter int LANES     = LANES_DEF,
  parameter int LANE_BITS = LANE_BITS_DEF,
  parameter int ADDR_BITS = ADDR_BITS_DEF,
  parameter int MEM_WORDS = 64
) (
  input  wire logic           clk,
  input  wire logic           rstn,
  sram_bus_if.device          bus,
  output logic                selected,
  output logic                standby,
  output logic [ADDR_BITS-1:0] burstAddr
);
  localparam int WIDTH  = LANES * LANE_BITS;
  localparam int IDX_W  = $clog2(MEM_WORDS);

  // ----------------------------------------
  // Mode pins and selection
  // ----------------------------------------
  logic flowThrough;
  logic interleaved;
  logic sleepNow;
  logic chipOn;
  logic loadAddr;
  logic isWrite;
  logic isRead;
  logic [LANES-1:0] laneWe;

  // Flow-through and sleep pins driven X/Z stand for an open pin: pull-up / pull-down default
  assign flowThrough = (bus.flowThroughSelect_n === 1'b0);
  assign sleepNow    = (bus.sleepRequest === 1'b1);
  assign interleaved = bus.linearOrderSelect_n;
  assign chipOn = !bus.chipSelectLowFirst_n && bus.chipSelectHigh
                  && !bus.chipSelectLowSecond_n;
  assign standby = sleepNow;

  // Processor strobe ignored while first low enable is high
  assign loadAddr = (!bus.processorAddrStrobe_n
                     && !bus.chipSelectLowFirst_n)
                    || !bus.controllerAddrStrobe_n;

  // ----------------------------------------
  // Access decode
  // ----------------------------------------
  logic wrCycle;
  always_comb begin
    laneWe = '0;
    // Processor strobe start is always a read
    wrCycle = !bus.globalWrite_n || !bus.byteWriteQualifier_n;
    if (loadAddr && !bus.processorAddrStrobe_n) begin
      wrCycle = 1'b0;
    end
    if (!bus.globalWrite_n) begin
      laneWe = '1;
    end else if (!bus.byteWriteQualifier_n) begin
      laneWe = ~bus.laneWrite_n;
    end
    if (!wrCycle) begin
      laneWe = '0;
    end
  end

  // ----------------------------------------
  // Burst state
  // ----------------------------------------
  logic [ADDR_BITS-1:0] baseAddr_r, baseAddr_nxt;
  logic [1:0]           beat_r, beat_nxt;
  logic                 active_r, active_nxt;
  logic [1:0]           curLow;
  logic [ADDR_BITS-1:0] curAddr;
  logic [1:0]           beatUse;

  assign isWrite = (loadAddr ? chipOn : active_r) && wrCycle && !sleepNow;
  assign isRead  = (loadAddr ? chipOn : active_r) && !wrCycle && !sleepNow;

  always_comb begin
    baseAddr_nxt = baseAddr_r;
    beat_nxt     = beat_r;
    active_nxt   = active_r;
    beatUse      = beat_r;
    if (sleepNow) begin
      active_nxt = 1'b0;
    end else if (loadAddr) begin
      baseAddr_nxt = bus.addr;
      beat_nxt     = BURST_ZERO;
      beatUse      = BURST_ZERO;
      active_nxt   = chipOn;
    end else if (active_r && !bus.burstStep_n) begin
      // Two-bit add drops the carry, so the fifth beat is the start
      beat_nxt = beat_r + BURST_STEP;
      beatUse  = beat_r + BURST_STEP;
    end
  end

  always_comb begin
    curAddr = loadAddr ? bus.addr : baseAddr_r;
    if (interleaved) begin
      curLow = curAddr[1:0] ^ beatUse;
    end else begin
      curLow = curAddr[1:0] + beatUse;
    end
    curAddr[1:0] = curLow;
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      baseAddr_r <= '0;
      beat_r     <= BURST_ZERO;
      active_r   <= 1'b0;
    end else begin
      baseAddr_r <= baseAddr_nxt;
      beat_r     <= beat_nxt;
      active_r   <= active_nxt;
    end
  end

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  logic [WIDTH-1:0] mem [MEM_WORDS];
  logic [IDX_W-1:0] idx;
  assign idx = curAddr[IDX_W-1:0];

  // Small model array; only low address bits index it
  always_ff @(posedge clk) begin
    for (int l = 0; l < LANES; l++) begin
      if (isWrite && laneWe[l]) begin
        mem[idx][l*LANE_BITS +: LANE_BITS] <=
          bus.dataLine[l*LANE_BITS +: LANE_BITS];
      end
    end
  end

  // ----------------------------------------
  // Read path and deselect pipeline
  // ----------------------------------------
  logic [WIDTH-1:0] flowData_r, flowData_nxt;
  logic [WIDTH-1:0] pipeData_r, pipeData_nxt;
  logic             flowOn_r, flowOn_nxt;
  logic             pipeOn_r, pipeOn_nxt;
  logic             pipeOn2_r, pipeOn2_nxt;

  // Flow-through presents data at the access edge,
  // pipeline one edge later; deselect walks the same stages
  always_comb begin
    flowData_nxt = isRead ? mem[idx] : flowData_r;
    flowOn_nxt   = isRead;
    pipeData_nxt = flowData_r;
    pipeOn_nxt   = flowOn_r;
    pipeOn2_nxt  = pipeOn_r;
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      flowData_r <= '0;
      pipeData_r <= '0;
      flowOn_r   <= 1'b0;
      pipeOn_r   <= 1'b0;
      pipeOn2_r  <= 1'b0;
    end else begin
      flowData_r <= flowData_nxt;
      pipeData_r <= pipeData_nxt;
      flowOn_r   <= flowOn_nxt;
      pipeOn_r   <= pipeOn_nxt;
      pipeOn2_r  <= pipeOn2_nxt;
    end
  end

  logic drvOn;
  // Drivers stay on until the first edge after a deselect (flow), the second (pipeline)
  assign drvOn = flowThrough ? (flowOn_r || pipeOn_r)
                             : (pipeOn_r || pipeOn2_r);
  assign bus.sramData   = flowThrough ? flowData_r : pipeData_r;
  // Write cycle in progress forces drivers off regardless of lanes
  assign bus.sramDataOe = {WIDTH{drvOn && !bus.outputEnable_n
                                 && !isWrite}};

  assign selected  = active_r;
  assign burstAddr = curAddr;
endmodule

// *** hdl/sram_burst_host.sv ***
`timescale 1ns/1ns
module sram_burst_host
  import sram_burst_pkg::*;
#(
  parameter int LANES     = LANES_DEF,
  parameter int LANE_BITS = LANE_BITS_DEF,
  parameter int ADDR_BITS = ADDR_BITS_DEF
) (
  input  wire logic                       clk,
  input  wire logic                       rstn,
  sram_bus_if.host                        bus,
  input  wire logic                       reqValid,
  input  wire logic                       reqWrite,
  input  wire logic                       reqByController,
  input  wire logic                       reqBurst,
  input  wire logic [ADDR_BITS-1:0]       reqAddr,
  input  wire logic [LANES-1:0]           reqLanes,
  input  wire logic                       reqAllLanes,
  input  wire logic [LANES*LANE_BITS-1:0] reqData,
  input  wire logic                       reqStep,
  input  wire logic                       reqOutputEnable,
  input  wire logic                       cfgFlowThrough,
  input  wire logic                       cfgInterleaved,
  input  wire logic                       cfgSleep,
  output logic [LANES*LANE_BITS-1:0]      rdData,
  output logic                            busy
);
  localparam int WIDTH = LANES * LANE_BITS;

  // ----------------------------------------
  // Registered pin drive
  // ----------------------------------------
  op_t                  op_r, op_nxt;
  logic [ADDR_BITS-1:0] addr_r, addr_nxt;
  logic                 strobeP_r, strobeP_nxt;
  logic                 strobeC_r, strobeC_nxt;
  logic                 step_r, step_nxt;
  logic                 gw_r, gw_nxt;
  logic                 bwq_r, bwq_nxt;
  logic [LANES-1:0]     lanes_r, lanes_nxt;
  logic [WIDTH-1:0]     wdata_r, wdata_nxt;
  logic [WIDTH-1:0]     rdData_r;

  always_comb begin
    op_nxt      = OP_IDLE;
    addr_nxt    = addr_r;
    strobeP_nxt = 1'b1;
    strobeC_nxt = 1'b1;
    step_nxt    = 1'b1;
    gw_nxt      = 1'b1;
    bwq_nxt     = 1'b1;
    lanes_nxt   = '1;
    wdata_nxt   = wdata_r;
    if (reqValid) begin
      op_nxt = reqWrite ? OP_WRITE : OP_READ;
      if (!reqBurst) begin
        addr_nxt = reqAddr;
        // Processor strobe cannot start a write
        if (reqByController || reqWrite) begin
          strobeC_nxt = 1'b0;
        end else begin
          strobeP_nxt = 1'b0;
        end
      end
      step_nxt = !(reqBurst && reqStep);
      if (reqWrite) begin
        wdata_nxt = reqData;
        if (reqAllLanes) begin
          gw_nxt = 1'b0;
        end else begin
          bwq_nxt   = 1'b0;
          lanes_nxt = ~reqLanes;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      op_r      <= OP_IDLE;
      addr_r    <= '0;
      strobeP_r <= 1'b1;
      strobeC_r <= 1'b1;
      step_r    <= 1'b1;
      gw_r      <= 1'b1;
      bwq_r     <= 1'b1;
      lanes_r   <= '1;
      wdata_r   <= '0;
      rdData_r  <= '0;
    end else begin
      op_r      <= op_nxt;
      addr_r    <= addr_nxt;
      strobeP_r <= strobeP_nxt;
      strobeC_r <= strobeC_nxt;
      step_r    <= step_nxt;
      gw_r      <= gw_nxt;
      bwq_r     <= bwq_nxt;
      lanes_r   <= lanes_nxt;
      wdata_r   <= wdata_nxt;
      rdData_r  <= bus.dataLine;
    end
  end

  // Chip enables tied asserted; device stays selected until sleep request
  assign bus.addr                   = addr_r;
  assign bus.chipSelectLowFirst_n   = 1'b0;
  assign bus.chipSelectHigh         = 1'b1;
  assign bus.chipSelectLowSecond_n  = 1'b0;
  assign bus.processorAddrStrobe_n  = strobeP_r;
  assign bus.controllerAddrStrobe_n = strobeC_r;
  assign bus.burstStep_n            = step_r;
  assign bus.globalWrite_n          = gw_r;
  assign bus.byteWriteQualifier_n   = bwq_r;
  assign bus.laneWrite_n            = lanes_r;
  assign bus.outputEnable_n         = !reqOutputEnable;
  assign bus.sleepRequest           = cfgSleep;
  assign bus.flowThroughSelect_n    = !cfgFlowThrough;
  assign bus.linearOrderSelect_n    = cfgInterleaved;
  assign bus.tieLowPin              = 1'b0;
  assign bus.hostData               = wdata_r;
  assign bus.hostDataOe             = {WIDTH{op_r == OP_WRITE}};
  assign rdData = rdData_r;
  assign busy   = (op_r != OP_IDLE);
endmodule

// *** verif/sram_burst_control_sva.sv ***
`timescale 1ns/1ns
module sram_burst_control_sva #(
  parameter int DW = 36
) (
  input wire logic          clk,
  input wire logic          rstn,
  input wire logic          tieLowPin,
  input wire logic          outputEnable_n,
  input wire logic          globalWrite_n,
  input wire logic          byteWriteQualifier_n,
  input wire logic          controllerAddrStrobe_n,
  input wire logic          processorAddrStrobe_n,
  input wire logic          flowThroughSelect_n,
  input wire logic [DW-1:0] hostDataOe,
  input wire logic [DW-1:0] sramDataOe
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  logic rdReq;
  logic wrCyc;
  assign rdReq = (!controllerAddrStrobe_n || !processorAddrStrobe_n) &&
                 globalWrite_n && byteWriteQualifier_n && !outputEnable_n;
  assign wrCyc = !globalWrite_n || !byteWriteQualifier_n;

  chk_tie_low: assert property (tieLowPin == 1'b0)
    else $error("tie-low pin driven high");
  chk_oe_gate: assert property (outputEnable_n |-> sramDataOe == '0)
    else $error("data driven with output enable off");
  chk_write_hiz: assert property (wrCyc |-> sramDataOe == '0)
    else $error("data driven during write");
  chk_lanes_whole: assert property (sramDataOe == '0 || sramDataOe == '1)
    else $error("partial lane drive");
  chk_no_fight: assert property ((hostDataOe & sramDataOe) == '0)
    else $error("both ends drive data");
  chk_gw_drive: assert property (!globalWrite_n |-> hostDataOe == '1)
    else $error("global write without full data drive");
  chk_read_flow: assert property (rdReq && !flowThroughSelect_n |->
    ##[1:2] sramDataOe == '1)
    else $error("flow read data late");
  chk_read_pipe: assert property (rdReq && flowThroughSelect_n |->
    ##[2:3] sramDataOe == '1)
    else $error("pipelined read data late");
  cov_write: cover property (wrCyc);
  cov_flow: cover property (rdReq && !flowThroughSelect_n);
  cov_pipe: cover property (rdReq && flowThroughSelect_n);
endmodule

// *** verif/sync_burst_sram_control_bench.sv ***
`timescale 1ns/1ns
module sync_burst_sram_control_bench;
  import sram_burst_pkg::*;
  logic clk, rstn, reqValid, reqWrite, reqByController, reqBurst, reqStep;
  logic [19:0] reqAddr, burstAddr;
  logic [3:0]  reqLanes;
  logic        reqAllLanes, reqOutputEnable, cfgFlowThrough, cfgInterleaved;
  logic        cfgSleep, busy, selected, standby;
  logic [35:0] reqData, rdData;
  logic [35:0] mdl [64];
  int          fails = 0, n_compared = 0;
  sram_bus_if bus ();
  sram_burst_device sram_burst_device_i (.clk(clk), .rstn(rstn), .bus(bus),
    .selected(selected), .standby(standby), .burstAddr(burstAddr));
  sram_burst_host sram_burst_host_i (.clk(clk), .rstn(rstn), .bus(bus),
    .reqValid(reqValid), .reqWrite(reqWrite),
    .reqByController(reqByController), .reqBurst(reqBurst),
    .reqAddr(reqAddr), .reqLanes(reqLanes), .reqAllLanes(reqAllLanes),
    .reqData(reqData), .reqStep(reqStep), .reqOutputEnable(reqOutputEnable),
    .cfgFlowThrough(cfgFlowThrough), .cfgInterleaved(cfgInterleaved),
    .cfgSleep(cfgSleep), .rdData(rdData), .busy(busy));
  sram_burst_control_sva sram_burst_control_sva_i (.clk(clk), .rstn(rstn),
    .tieLowPin(bus.tieLowPin), .outputEnable_n(bus.outputEnable_n),
    .globalWrite_n(bus.globalWrite_n),
    .byteWriteQualifier_n(bus.byteWriteQualifier_n),
    .controllerAddrStrobe_n(bus.controllerAddrStrobe_n),
    .processorAddrStrobe_n(bus.processorAddrStrobe_n),
    .flowThroughSelect_n(bus.flowThroughSelect_n),
    .hostDataOe(bus.hostDataOe), .sramDataOe(bus.sramDataOe));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input logic [35:0] s, input logic [35:0] e);
    n_compared++;
    if (s !== e) begin
      fails++;
      $display("unexpected at %0t: saw %h want %h", $time, s, e);
    end
  endtask
  task automatic complete_run();
    $display("compared %0d, mismatched %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic req(input logic w, ctl, bst, stp, input logic [5:0] a);
    reqValid = 1'b1;
    reqWrite = w;
    reqByController = ctl;
    reqBurst = bst;
    reqStep = stp;
    reqAddr = {14'h0, a};
    @(negedge clk);
    reqValid = 1'b0;
  endtask
  task automatic wr(input logic [5:0] a, input logic [3:0] ln, input logic al);
    reqData = 36'({$urandom, $urandom});
    reqLanes = ln;
    reqAllLanes = al;
    for (int l = 0; l < 4; l++) begin
      if (al || ln[l]) mdl[a][l*9+:9] = reqData[l*9+:9];
    end
    req(1'b1, 1'b1, 1'b0, 1'b0, a);
  endtask
  // Host samples the bus one edge after the device shows it, so the
  // read data lands two edges (flow) or three (pipeline) after this
  task automatic rd(input logic [5:0] a, input logic ctl);
    req(1'b0, ctl, 1'b0, 1'b0, a);
    check(busy, 1'b1);
    repeat (cfgFlowThrough ? 2 : 3) @(negedge clk);
    check(rdData, mdl[a]);
    check(busy, 1'b0);
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [5:0] b;
    logic [1:0] s, n;
    {rstn, reqValid, reqWrite, reqByController, reqBurst, reqStep} = '0;
    {reqAddr, reqLanes, reqAllLanes, reqData, cfgSleep} = '0;
    {cfgFlowThrough, cfgInterleaved, reqOutputEnable} = 3'h1;
    n = 2'($urandom(32'h1611));
    repeat (12) @(posedge clk);
    @(negedge clk);
    rstn = 1'b1;
    for (int m = 0; m < 2; m++) begin
      cfgFlowThrough = m[0];
      for (int i = 0; i < 4; i++) begin
        wr(6'(i * 5), 4'h0, 1'b1);
        rd(6'(i * 5), 1'b1);
      end
    end
    $display("test global write done");
    // Known contents first, so partial lane writes never leave unknowns
    wr(6'h21, 4'h0, 1'b1);
    rd(6'h21, 1'b1);
    for (int i = 0; i < 8; i++) begin
      wr(6'h21, (i == 0) ? 4'h0 : 4'($urandom), 1'b0);
      rd(6'h21, i[0]);
    end
    $display("test lane write done");
    for (int il = 0; il < 2; il++) begin
      cfgInterleaved = il[0];
      reqOutputEnable = il[0];
      b = 6'($urandom & 6'h3C);
      s = 2'($urandom);
      n = 2'h0;
      for (int k = 0; k < 6; k++) begin
        if (6'b111010 >> k & 1) n = n + 2'h1;
        req(1'b0, 1'b1, k > 0, 6'b111010 >> k & 1, b | s);
        check(burstAddr, {14'h0, b | (il ? s ^ n : 2'(s + n))});
      end
    end
    reqOutputEnable = 1'b1;
    $display("test burst done");
    cfgSleep = 1'b1;
    @(negedge clk);
    check(standby, 1'b1);
    check(selected, 1'b0);
    cfgSleep = 1'b0;
    @(negedge clk);
    check(standby, 1'b0);
    rd(6'h0A, 1'b1);
    $display("test sleep done");
    complete_run();
  end
endmodule
